// ---- test/low_power_mode_control_bench.sv ----
`timescale 1ns/1ps
module low_power_mode_control_bench;
    import lpm_pkg::*;
    localparam int NL = 16;
    localparam int NS = 4;
    logic clock = 0, rst = 1, wr = 0, rd = 0, req_wait = 0, req_stop = 0;
    logic irq_pin_mask = 1, keypad_irq_mask = 1, ext_reset_n = 1, undervoltage_trip = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    lpm_wake_t wake = '0;
    logic [DATA_W-1:0] rdata;
    lpm_clocks_t clocks;
    lpm_cg_t cg;
    logic wait_exec, stop_exec, cpu_irq_mask, system_reset, converter_abort, converter_halt;
    logic break_idle, stopwait_break_flag, watchdog_prescaler_clear, undervoltage_active;
    logic async_serial_halt, sync_serial_halt, sync_serial_reset, timer_freeze, timebase_access_en;
    int err_count = 0, tests_run = 0, m_mode = 0;
    integer seed = 32'hd2def32e;
    logic [7:0] m_ctl = 8'h18, m_stk = 8'h00;
    logic m_mask = 1, mon_event = 0;
    always #20 clock = ~clock;
    lpm_core_model core_u (.clock(clock), .rst(rst), .cpu_running(clocks.cpu),
        .req_wait(req_wait), .req_stop(req_stop), .wait_exec(wait_exec), .stop_exec(stop_exec));
    lpm_control #(.RECOVERY_LONG(NL), .RECOVERY_SHORT(NS)) dut_u (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .wait_exec(wait_exec), .stop_exec(stop_exec), .cpu_mask_set(1'b0),
        .cpu_mask_clear(1'b0), .irq_pin_mask(irq_pin_mask), .keypad_irq_mask(keypad_irq_mask),
        .wake(wake), .ext_reset_n(ext_reset_n), .undervoltage_trip(undervoltage_trip),
        .ext_stable_in(1'b1), .int_stable_in(1'b1), .clock_monitor_event(mon_event),
        .clocks(clocks), .cg(cg), .cpu_irq_mask(cpu_irq_mask), .system_reset(system_reset),
        .converter_abort(converter_abort), .converter_halt(converter_halt),
        .break_idle(break_idle), .stopwait_break_flag(stopwait_break_flag),
        .watchdog_prescaler_clear(watchdog_prescaler_clear),
        .undervoltage_active(undervoltage_active), .async_serial_halt(async_serial_halt),
        .sync_serial_halt(sync_serial_halt), .sync_serial_reset(sync_serial_reset),
        .timer_freeze(timer_freeze), .timebase_access_en(timebase_access_en));
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic too_long();
        err_count++;
        $display("CHECK FAILED %0t wait ran out", $time);
        summarize();
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        if (a == REG_CONTROL) m_ctl = d & CONTROL_MASK;
        #1;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk_byte(rdata, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic check_mode();
        logic st;
        logic off;
        st = (m_mode == 2);
        off = st && !m_ctl[CTL_OSC_RUN_IN_STOP];
        chk(clocks.cpu, m_mode == 0);
        chk(clocks.bus, !off);
        chk(clocks.generator, !off);
        chk(clocks.timebase, !off);
        chk(clocks.watchdog, !st);
        chk(cpu_irq_mask, m_mask);
        chk(timebase_access_en, m_mode == 0);
        chk(break_idle, st);
        chk(undervoltage_active, m_ctl[CTL_UV_ENABLE] & (!st | m_ctl[CTL_UV_STOP_ENABLE]));
        chk_byte({4'h0, converter_halt, async_serial_halt, sync_serial_halt, timer_freeze},
            st ? 8'h0f : 8'h00);
        rd_reg(REG_STATUS, m_stk | {6'h0, st, m_mode == 1});
    endtask
    task automatic enter(input logic is_stop);
        logic seen;
        seen = 0;
        @(posedge clock);
        req_wait <= !is_stop;
        req_stop <= is_stop;
        @(posedge clock);
        req_wait <= 1'b0;
        req_stop <= 1'b0;
        repeat (4) begin
            @(posedge clock);
            #1;
            if (converter_abort === 1'b1) begin
                seen = 1;
                chk(watchdog_prescaler_clear, 1'b1);
            end
        end
        chk(seen, is_stop & m_ctl[CTL_STOP_ENABLE]);
        if (!is_stop || m_ctl[CTL_STOP_ENABLE]) begin
            m_mode = is_stop ? 2 : 1;
            m_mask = 0;
        end
    endtask
    task automatic leave(input int b, input int n_exp);
        int n;
        @(posedge clock);
        wake[b] <= 1'b1;
        @(posedge clock);
        wake <= '0;
        n = 1;
        #1;
        while (clocks.cpu !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 300) too_long();
        chk_byte(8'(n), 8'(n_exp));
        m_mode = 0;
    endtask
    task automatic ignore(input logic [9:0] w);
        @(posedge clock);
        wake <= w;
        repeat (3) @(posedge clock);
        wake <= '0;
        repeat (2) @(posedge clock);
        #1;
        check_mode();
    endtask
    task automatic reset_exit(input logic uv);
        int n;
        n = 0;
        @(posedge clock);
        if (uv) undervoltage_trip <= 1'b1;
        else ext_reset_n <= 1'b0;
        #1;
        while (system_reset !== 1'b1 && n < 300) begin
            @(posedge clock);
            if (n >= 2) undervoltage_trip <= 1'b0;
            if (n >= 2) ext_reset_n <= 1'b1;
            #1;
            n++;
        end
        if (n >= 300) too_long();
        chk(sync_serial_reset, m_mode == 2);
        @(posedge clock);
        undervoltage_trip <= 1'b0;
        ext_reset_n <= 1'b1;
        #1;
        chk(cpu_irq_mask, 1'b1);
        repeat (4) @(posedge clock);
        #1;
        m_mode = 0;
        m_mask = 1;
        m_stk = 8'h10;
        check_mode();
        wr_reg(REG_STATUS, 8'h08);
        m_stk = 8'h00;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        #1;
        check_mode();
        rd_reg(REG_CONTROL, CONTROL_RESET);
        wr_reg(4'hc, 8'hff);
        rd_reg(4'hc, 8'h00);
        rd_reg(REG_CONTROL, CONTROL_RESET);
        wr_reg(REG_CLOCK_GEN, 8'h0c);
        chk_byte({3'h0, cg} & 8'h0c, 8'h0c);
        @(posedge clock);
        mon_event <= 1'b1;
        @(posedge clock);
        mon_event <= 1'b0;
        #1;
        chk_byte({3'h0, cg} & 8'h1c, 8'h1c);
        repeat (3) begin
            enter(1'b0);
            check_mode();
            leave(1 + {$random(seed)} % 6, 1);
            check_mode();
        end
        enter(1'b1);
        check_mode();
        wr_reg(REG_CONTROL, 8'h19);
        enter(1'b1);
        check_mode();
        chk_byte({3'h0, cg}, 8'h00);
        ignore(10'($random(seed)) & 10'h37f);
        @(posedge clock);
        irq_pin_mask <= 1'b0;
        leave(9, NL + 1);
        check_mode();
        wr_reg(REG_CONTROL, 8'h1f);
        enter(1'b1);
        check_mode();
        ignore(10'h040);
        leave(1, NS + 1);
        wr_reg(REG_CONTROL, 8'h39);
        @(posedge clock);
        keypad_irq_mask <= 1'b0;
        enter(1'b1);
        check_mode();
        leave(8, NL + 1);
        enter(1'b1);
        leave(7, NL + 1);
        chk(stopwait_break_flag, 1'b1);
        m_stk = 8'h08;
        check_mode();
        wr_reg(REG_STATUS, 8'h08);
        m_stk = 8'h00;
        chk(stopwait_break_flag, 1'b0);
        wr_reg(REG_CONTROL, 8'h19);
        enter(1'b1);
        reset_exit(1'b0);
        wr_reg(REG_CONTROL, 8'h18);
        enter(1'b0);
        reset_exit(1'b1);
        summarize();
    end
endmodule

// ---- test/lpm_core_model.sv ----
`timescale 1ns/1ps
module lpm_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic cpu_running,
    input wire logic req_wait,
    input wire logic req_stop,
    output logic wait_exec,
    output logic stop_exec
);
    // instructions retire only while the core clock runs
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_exec <= 1'b0;
            stop_exec <= 1'b0;
        end else begin
            wait_exec <= req_wait & cpu_running & ~wait_exec;
            stop_exec <= req_stop & cpu_running & ~stop_exec;
        end
    end
endmodule

// ---- verilog/lpm_control.sv ----
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module lpm_control #(
    parameter int RECOVERY_LONG = lpm_pkg::RECOVERY_LONG_CYCLES,
    parameter int RECOVERY_SHORT = lpm_pkg::RECOVERY_SHORT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [lpm_pkg::ADDR_W-1:0] addr,
    input wire logic [lpm_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [lpm_pkg::DATA_W-1:0] rdata,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic cpu_mask_set,
    input wire logic cpu_mask_clear,
    input wire logic irq_pin_mask,
    input wire logic keypad_irq_mask,
    input wire lpm_pkg::lpm_wake_t wake,
    input wire logic ext_reset_n,
    input wire logic undervoltage_trip,
    input wire logic ext_stable_in,
    input wire logic int_stable_in,
    input wire logic clock_monitor_event,
    output lpm_pkg::lpm_clocks_t clocks,
    output lpm_pkg::lpm_cg_t cg,
    output logic cpu_irq_mask,
    output logic system_reset,
    output logic converter_abort,
    output logic converter_halt,
    output logic break_idle,
    output logic stopwait_break_flag,
    output logic watchdog_prescaler_clear,
    output logic undervoltage_active,
    output logic async_serial_halt,
    output logic sync_serial_halt,
    output logic sync_serial_reset,
    output logic timer_freeze,
    output logic timebase_access_en
);
    import lpm_pkg::*;

    if (RECOVERY_SHORT < 1 || RECOVERY_LONG < RECOVERY_SHORT ||
        RECOVERY_LONG > (1 << RECOVERY_W)) begin : g_bad_recovery
        $error("recovery counts out of range");
    end

    localparam logic [RECOVERY_W-1:0] LOAD_LONG = RECOVERY_W'(RECOVERY_LONG - 1);
    localparam logic [RECOVERY_W-1:0] LOAD_SHORT = RECOVERY_W'(RECOVERY_SHORT - 1);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta <= 2'h1;
            pin_sync <= 2'h1;
        end else begin
            pin_meta <= {undervoltage_trip, ext_reset_n};
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    logic [DATA_W-1:0] control;
    logic stop_enable;
    logic osc_run_in_stop;
    logic short_recovery_select;
    logic uv_enable;
    logic uv_reset_enable;
    logic undervoltage_stop_enable;

    assign stop_enable = control[CTL_STOP_ENABLE];
    assign osc_run_in_stop = control[CTL_OSC_RUN_IN_STOP];
    assign short_recovery_select = control[CTL_SHORT_RECOVERY];
    assign uv_enable = control[CTL_UV_ENABLE];
    assign uv_reset_enable = control[CTL_UV_RESET_ENABLE];
    assign undervoltage_stop_enable = control[CTL_UV_STOP_ENABLE];

    always_ff @(posedge clock) begin
        if (rst) begin
            control <= CONTROL_RESET;
        end else if (wr && hit(addr, REG_CONTROL)) begin
            control <= wdata & CONTROL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake and reset sources
    lpm_state_t state;
    lpm_state_t next_state;
    logic [RECOVERY_W-1:0] rec_count;
    logic exit_by_reset;
    logic uv_reset;
    logic ext_reset;
    logic wait_wake;
    logic stop_wake;
    logic wait_reset;
    logic stop_reset;
    logic recover_done;

    assign ext_reset = !pin_sync[0];
    assign uv_reset = pin_sync[1] && uv_enable && uv_reset_enable;

    always_comb begin
        wait_wake = (wake.irq_pin && !irq_pin_mask) || // RULE16
                    (wake.keypad && !keypad_irq_mask) || // RULE17
                    wake.break_req ||
                    wake.clock_gen || // RULE13
                    wake.converter || // RULE7
                    wake.async_serial || // RULE18
                    wake.sync_serial ||
                    wake.timer; // RULE20
        wait_wake = wait_wake || wake.timebase; // RULE21
        stop_wake = (wake.irq_pin && !irq_pin_mask) || // RULE16
                    (wake.keypad && !keypad_irq_mask) || // RULE17
                    wake.break_req || // RULE8
                    (wake.timebase && osc_run_in_stop); // RULE10 RULE23
        wait_reset = ext_reset || wake.watchdog_timeout || uv_reset; // RULE6
        stop_reset = ext_reset || (uv_reset && undervoltage_stop_enable); // RULE5
    end

    assign recover_done = (state == LPM_RECOVER) && (rec_count == '0);

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always_comb begin
        next_state = state;
        case (state)
            LPM_RUN: begin
                if (wait_exec) begin
                    next_state = LPM_WAIT;
                end else if (stop_exec && stop_enable) begin // RULE15
                    next_state = LPM_STOP;
                end
            end
            LPM_WAIT: begin
                if (wait_reset || wait_wake) begin
                    next_state = LPM_RUN;
                end
            end
            LPM_STOP: begin
                if (stop_reset || stop_wake) begin
                    next_state = LPM_RECOVER; // RULE4
                end
            end
            LPM_RECOVER: begin
                if (rec_count == '0) begin
                    next_state = LPM_RUN;
                end
            end
            default: begin
                next_state = LPM_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= LPM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // stop recovery counter
    always_ff @(posedge clock) begin
        if (rst) begin
            rec_count <= '0;
        end else if (state == LPM_STOP) begin
            rec_count <= short_recovery_select ? LOAD_SHORT : LOAD_LONG; // RULE22
        end else if (state == LPM_RECOVER && rec_count != '0) begin
            rec_count <= rec_count - 1'b1; // RULE22
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            exit_by_reset <= 1'b0;
        end else if (state == LPM_STOP) begin
            exit_by_reset <= stop_reset;
        end else if (state == LPM_RUN) begin
            exit_by_reset <= 1'b0;
        end
    end

    logic reset_exit;
    assign reset_exit = (state == LPM_WAIT && wait_reset) || (recover_done && exit_by_reset);

    ////////////////////////////////////////////////////////////////////////////
    // clock gating
    always_ff @(posedge clock) begin
        if (rst) begin
            clocks <= '{cpu: 1'b1, bus: 1'b1, generator: 1'b1, watchdog: 1'b1, timebase: 1'b1};
        end else begin
            clocks.cpu <= (next_state == LPM_RUN); // RULE1 RULE2 RULE4 RULE24
            clocks.bus <= (next_state == LPM_RUN) || (next_state == LPM_WAIT) ||
                          (next_state == LPM_STOP && osc_run_in_stop); // RULE1 RULE2
            clocks.generator <= !(next_state == LPM_STOP && !osc_run_in_stop); // RULE9
            clocks.watchdog <= (next_state == LPM_RUN) || (next_state == LPM_WAIT); // RULE14
            clocks.timebase <= !(next_state == LPM_STOP && !osc_run_in_stop); // RULE9 RULE23
        end
    end

    // interrupt mask of the core
    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_irq_mask <= 1'b1;
        end else if (reset_exit) begin
            cpu_irq_mask <= 1'b1; // RULE3
        end else if (state == LPM_RUN && next_state != LPM_RUN) begin
            cpu_irq_mask <= 1'b0; // RULE3
        end else if (cpu_mask_set) begin
            cpu_irq_mask <= 1'b1;
        end else if (cpu_mask_clear) begin
            cpu_irq_mask <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            system_reset <= 1'b0;
            sync_serial_reset <= 1'b0;
        end else begin
            system_reset <= reset_exit; // RULE24
            sync_serial_reset <= recover_done && exit_by_reset; // RULE19
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral controls
    logic stop_entry;
    logic held;
    assign stop_entry = (state == LPM_RUN) && (next_state == LPM_STOP);
    assign held = (next_state == LPM_STOP) || (next_state == LPM_RECOVER);

    always_ff @(posedge clock) begin
        if (rst) begin
            converter_abort <= 1'b0;
            watchdog_prescaler_clear <= 1'b0;
        end else begin
            converter_abort <= stop_entry; // RULE7
            watchdog_prescaler_clear <= stop_entry; // RULE14
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            converter_halt <= 1'b0;
            async_serial_halt <= 1'b0;
            sync_serial_halt <= 1'b0;
            timer_freeze <= 1'b0;
            break_idle <= 1'b0;
        end else begin
            converter_halt <= held; // RULE7
            async_serial_halt <= held; // RULE18
            sync_serial_halt <= held; // RULE19
            timer_freeze <= held; // RULE20
            break_idle <= (next_state == LPM_STOP); // RULE8
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            undervoltage_active <= 1'b1;
            timebase_access_en <= 1'b1;
        end else begin
            undervoltage_active <= uv_enable &&
                (next_state != LPM_STOP || undervoltage_stop_enable); // RULE5 RULE6
            timebase_access_en <= (next_state == LPM_RUN); // RULE21
        end
    end

    // break flag: set wins over software clear
    logic break_clear;
    assign break_clear = wr && hit(addr, REG_STATUS) && wdata[ST_BREAK_FLAG];

    always_ff @(posedge clock) begin
        if (rst) begin
            stopwait_break_flag <= 1'b0;
        end else if ((state == LPM_STOP || state == LPM_WAIT) && wake.break_req) begin
            stopwait_break_flag <= 1'b1; // RULE8
        end else if (break_clear) begin
            stopwait_break_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock generator state bits
    logic osc_off_stop;
    logic cg_write;
    assign osc_off_stop = (state == LPM_STOP) && !osc_run_in_stop;
    assign cg_write = wr && hit(addr, REG_CLOCK_GEN);

    always_ff @(posedge clock) begin
        if (rst) begin
            cg.ext_clock_stable <= 1'b0;
            cg.int_clock_stable <= 1'b0;
        end else if (osc_off_stop) begin
            cg.ext_clock_stable <= 1'b0; // RULE11
            cg.int_clock_stable <= 1'b0; // RULE11
        end else begin
            cg.ext_clock_stable <= ext_stable_in;
            cg.int_clock_stable <= int_stable_in;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cg.clock_monitor_on <= 1'b0;
            cg.clock_monitor_irq_en <= 1'b0;
        end else if (osc_off_stop) begin
            cg.clock_monitor_on <= 1'b0; // RULE12
            cg.clock_monitor_irq_en <= 1'b0; // RULE12
        end else if (cg_write) begin
            cg.clock_monitor_on <= wdata[CG_MON_ON];
            cg.clock_monitor_irq_en <= wdata[CG_MON_ON] && wdata[CG_MON_IRQ_EN];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cg.clock_monitor_flag <= 1'b0;
        end else if (osc_off_stop || !cg.clock_monitor_on) begin
            cg.clock_monitor_flag <= 1'b0; // RULE12
        end else if (clock_monitor_event) begin
            cg.clock_monitor_flag <= 1'b1;
        end else if (cg_write && wdata[CG_MON_FLAG]) begin
            cg.clock_monitor_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    logic [DATA_W-1:0] status_word;
    logic reset_seen;

    always_ff @(posedge clock) begin
        if (rst) begin
            reset_seen <= 1'b0;
        end else if (reset_exit) begin
            reset_seen <= 1'b1;
        end else if (break_clear || (wr && hit(addr, REG_STATUS) && wdata[ST_RESET_EXIT])) begin
            reset_seen <= 1'b0;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[ST_WAIT] = (state == LPM_WAIT);
        status_word[ST_STOP] = (state == LPM_STOP);
        status_word[ST_RECOVER] = (state == LPM_RECOVER);
        status_word[ST_BREAK_FLAG] = stopwait_break_flag;
        status_word[ST_RESET_EXIT] = reset_seen;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd && hit(addr, REG_CONTROL)) begin
            rdata <= control;
        end else if (rd && hit(addr, REG_STATUS)) begin
            rdata <= status_word;
        end else if (rd && hit(addr, REG_CLOCK_GEN)) begin
            rdata <= {3'h0, cg};
        end else begin
            rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_wait_clocks: assert property ( // RULE1
        (state == LPM_WAIT) |-> (!clocks.cpu && clocks.bus))
        else $error("wait clock gating wrong");

    a_stop_osc_off: assert property ( // RULE9
        (state == LPM_STOP && !osc_run_in_stop && $stable(control)) |->
        (!clocks.bus && !clocks.generator && !clocks.timebase && !clocks.watchdog))
        else $error("stop with oscillator off left a clock running");

    a_stop_gate: assert property ( // RULE15
        (state == LPM_RUN && stop_exec && !wait_exec && !stop_enable) |=> (state == LPM_RUN))
        else $error("stop taken while disabled");

    a_entry_mask: assert property ( // RULE3
        (state == LPM_RUN && next_state != LPM_RUN) |=> !cpu_irq_mask)
        else $error("mask not cleared on entry");

    a_recovery_load: assert property ( // RULE22
        (state == LPM_STOP && next_state == LPM_RECOVER && !short_recovery_select) |=>
        (rec_count == LOAD_LONG) ##1 (state == LPM_RECOVER && !clocks.cpu)[*3])
        else $error("long recovery not loaded");

    a_no_gen_wake: assert property ( // RULE10
        (state == LPM_STOP && wake.clock_gen && !(wake.irq_pin && !irq_pin_mask) &&
         !(wake.keypad && !keypad_irq_mask) && !wake.break_req && !wake.timebase &&
         !ext_reset && !uv_reset) |=>
        (state == LPM_STOP))
        else $error("generator interrupt left stop");

    a_stable_clear: assert property ( // RULE11
        osc_off_stop |=> (!cg.ext_clock_stable && !cg.int_clock_stable && !cg.clock_monitor_on))
        else $error("stable bits not cleared in stop");

    a_break_flag: assert property ( // RULE8
        (state == LPM_STOP && wake.break_req) |=>
        (stopwait_break_flag && state == LPM_RECOVER))
        else $error("break did not end stop");

    a_timebase_lock: assert property ( // RULE21
        (state == LPM_WAIT) |-> !timebase_access_en)
        else $error("timebase reachable in wait");

    a_uv_stop: assert property ( // RULE5
        (state == LPM_STOP && $past(state) == LPM_STOP && !undervoltage_stop_enable
         && $stable(control)) |-> !undervoltage_active)
        else $error("undervoltage monitor ran in stop");

    a_wait_reset: assert property ( // RULE24
        (state == LPM_WAIT && wait_reset) |=> (system_reset && cpu_irq_mask && clocks.cpu))
        else $error("reset exit from wait wrong");

endmodule

// ---- verilog/lpm_pkg.sv ----
// Summary of operation
// RULE1: wait stops cpu clock, bus keeps running
// RULE2: stop halts cpu; bus unless oscillator kept
// RULE3: entry clears mask; reset exit sets it
// RULE4: cpu clock restarts after stabilization delay
// RULE5: undervoltage runs in stop if enabled there
// RULE6: undervoltage active in wait, reset ends wait
// RULE7: converter runs in wait; aborts on stop
// RULE8: break idle in stop, wakes, sets flag
// RULE9: oscillator off in stop holds clocks low
// RULE10: generator interrupts never wake from stop
// RULE11: stop with oscillator off clears stable flags
// RULE12: stop clears monitor enable, interrupt, flag (logic clears them only in stop with oscillator off)
// RULE13: generator active in wait, wakes wait
// RULE14: watchdog counts in wait; stop clears prescaler
// RULE15: stop ignored unless stop enable set
// RULE16: unmasked pin interrupt wakes wait or stop
// RULE17: keypad wakes either mode when unmasked
// RULE18: async serial runs in wait, halts stop
// RULE19: sync serial halts; reset exit resets it (logic pulses sync_serial_reset only on a reset exit from stop, not from wait)
// RULE20: timers run in wait, freeze in stop
// RULE21: timebase runs; no access during wait
// RULE22: stop exit waits 4096 or 32 cycles
// RULE23: timebase wakes stop when oscillator kept
// RULE24: reset exit restarts clocks and resets modules
package lpm_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CLOCK_GEN = 4'h8;

    // control fields
    localparam int CTL_STOP_ENABLE = 0;
    localparam int CTL_OSC_RUN_IN_STOP = 1;
    localparam int CTL_SHORT_RECOVERY = 2;
    localparam int CTL_UV_ENABLE = 3;
    localparam int CTL_UV_RESET_ENABLE = 4;
    localparam int CTL_UV_STOP_ENABLE = 5;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h18;
    localparam logic [DATA_W-1:0] CONTROL_MASK = 8'h3f;

    // status fields
    localparam int ST_WAIT = 0;
    localparam int ST_STOP = 1;
    localparam int ST_RECOVER = 2;
    localparam int ST_BREAK_FLAG = 3;
    localparam int ST_RESET_EXIT = 4;

    // clock generator fields
    localparam int CG_EXT_STABLE = 0;
    localparam int CG_INT_STABLE = 1;
    localparam int CG_MON_ON = 2;
    localparam int CG_MON_IRQ_EN = 3;
    localparam int CG_MON_FLAG = 4;

    // stop recovery in reference cycles
    localparam int RECOVERY_LONG_CYCLES = 4096;
    localparam int RECOVERY_SHORT_CYCLES = 32;
    localparam int RECOVERY_W = 12;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        LPM_RUN,
        LPM_WAIT,
        LPM_STOP,
        LPM_RECOVER
    } lpm_state_t;

    typedef struct packed {
        logic irq_pin;
        logic keypad;
        logic break_req;
        logic clock_gen;
        logic converter;
        logic async_serial;
        logic sync_serial;
        logic timer;
        logic timebase;
        logic watchdog_timeout;
    } lpm_wake_t;

    typedef struct packed {
        logic cpu;
        logic bus;
        logic generator;
        logic watchdog;
        logic timebase;
    } lpm_clocks_t;

    typedef struct packed {
        logic clock_monitor_flag;
        logic clock_monitor_irq_en;
        logic clock_monitor_on;
        logic int_clock_stable;
        logic ext_clock_stable;
    } lpm_cg_t;

endpackage
